// ==== shared/uart9_pkg.sv ====
// Constants shared by the nine-bit serial port and its buffer.
// Assumes a single system clock that stands in for the oscillator clock.
package uart9_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STATES_PER_CYCLE = 4;
  localparam logic [1:0] STATE_ONE = 2'h0;
  localparam logic [5:0] TICK_DIV_NORMAL = 6'h04;
  localparam logic [5:0] TICK_DIV_DOUBLE = 6'h02;
  localparam logic [3:0] SLICE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] TX_BITS = 4'hB;
  localparam logic [3:0] RX_BITS = 4'hA;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned WORD_W = 9;
  typedef enum logic [2:0]
  {
    RX_IDLE = 3'h1,
    RX_SHIFT = 3'h2,
    RX_LOAD = 3'h4
  } rx_state_t;
endpackage

// ==== shared/word_stream_if.sv ====
// Valid/ready word stream between the transmit buffer and the serial port.
// Assumes producer and consumer share clk_sys.
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ==== logic/word_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
// Assumes an active-low reset whose release is already synchronised to clk_sys.
`timescale 1ns/1ps
module word_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  word_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out.valid = (count_reg != '0);
  assign out.data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo

// ==== logic/serial_port_nine_bit.sv ====
// Nine-bit asynchronous full-duplex serial port with a four-word transmit buffer.
// Assumes rxd is asynchronous; software pulses write strobes and flag clears on clk_sys.
// What this block does
// [RULE1] Each frame spans exactly eleven bit times, full duplex.
// [RULE2] Frame starts with a low start bit, then eight data bits LSB first.
// [RULE3] Transmitted ninth bit comes from the tx_ninth_bit control.
// [RULE4] Received ninth bit lands in the rx_ninth_bit status.
// [RULE5] Bit rate is oscillator/32 or /64, chosen by baud_double_select.
// [RULE6] Only a serial_buffer write starts a transmission.
// [RULE7] Each transmit bit changes in state one after a divide-by-16 rollover.
// [RULE8] After the nine data bits, the stop bit is sent.
// [RULE9] tx_done_flag sets at state one of the eleventh rollover after the write.
// [RULE10] Receiver accepts frames only while receive enable is high.
// [RULE11] Reception starts on a falling edge, watched at sixteen times bit rate; the code looks for the edge on every clk_sys cycle.
// [RULE12] A falling edge resets the receive divide-by-16 counter immediately.
// [RULE13] Bit value is the majority of samples at counter states seven, eight, nine.
// [RULE14] A start bit resolving high aborts and rearms edge detection.
// [RULE15] After nine data bits and one more bit time, with no shift, buffer, ninth bit and flag load.
// [RULE16] Stop bit is high and the line idles high.
// [RULE17] Done flags stay set until cleared; interrupt request while either is set.
`timescale 1ns/1ps
module serial_port_nine_bit
  import uart9_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Software side
  input wire logic [7:0] serial_buffer_wdata,
  input wire logic serial_buffer_write,
  output logic serial_buffer_ready,
  input wire logic tx_ninth_bit,
  input wire logic baud_double_select,
  input wire logic rx_enable,
  output logic [7:0] serial_buffer_rdata,
  output logic rx_ninth_bit,
  output logic tx_done_flag,
  output logic rx_done_flag,
  input wire logic tx_done_clear,
  input wire logic rx_done_clear,
  output logic serial_irq,
  // Serial lines
  output logic txd,
  input wire logic rxd
);
  logic rst_meta_reg;
  logic rst_n;
  logic rxd_meta_reg;
  logic rxd_reg;
  logic rxd_prev_reg;
  logic [1:0] state_reg;
  logic [5:0] tick_cnt_reg;
  logic tick;
  logic state_one;
  logic [3:0] tx_div_reg;
  logic tx_roll;
  logic tx_busy_reg;
  logic [3:0] tx_cnt_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0] rx_div_reg;
  logic [3:0] rx_cnt_reg;
  logic [8:0] rx_shift_reg;
  logic [2:0] vote_reg;
  logic rx_bit;
  logic fall;
  rx_state_t rx_state_reg;
  word_stream_if #(.W(WORD_W)) txq ();

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Receive pin synchroniser; only rxd_reg and rxd_prev_reg are looked at by logic.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= rxd;
      rxd_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_reg;
    end
  end

  // One machine state per oscillator period, four per cycle; a tick is one slice of a bit.
  // Oscillator rate is clk_sys, so a bit is 32 or 64 clocks.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= STATE_ONE;
    else
      state_reg <= state_reg + 2'h1;
  end
  assign state_one = (state_reg == STATE_ONE);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 6'h01;
  end
  // Compared with at-or-above so that a rate change never strands the count past its end.
  assign tick = (tick_cnt_reg >= ((baud_double_select ? TICK_DIV_DOUBLE
                                                      : TICK_DIV_NORMAL) - 6'h01)); // [RULE5]

  // Buffer between software writes and the shifter; only writes feed it.
  word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(serial_buffer_write), // [RULE6]
    .in_ready(serial_buffer_ready),
    .in_data({tx_ninth_bit, serial_buffer_wdata}), // [RULE3]
    .out(txq.src)
  );

  // Transmit divide-by-16 runs freely, so frames align to its rollover, not the write.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tx_div_reg <= '0;
    else if (tick)
      tx_div_reg <= tx_div_reg + 4'h1;
  end
  assign tx_roll = tick && (tx_div_reg == SLICE_LAST);
  assign txq.ready = !tx_busy_reg;

  // Rollover seen on its tick; the bit is placed at the next state one.
  // Only rollovers while a frame is loaded count, so none from before the write leaks in.
  logic tx_roll_pend_reg;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tx_roll_pend_reg <= 1'b0;
    else if (tx_roll && tx_busy_reg)
      tx_roll_pend_reg <= 1'b1;
    else if (state_one || !tx_busy_reg)
      tx_roll_pend_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= '0;
      tx_shift_reg <= '1;
    end
    else if (!tx_busy_reg && txq.valid)
    begin
      tx_busy_reg <= 1'b1;
      tx_cnt_reg <= '0;
      tx_shift_reg <= {1'b1, txq.data, 1'b0}; // [RULE2] [RULE8] [RULE16]
    end
    else if (tx_busy_reg && tx_roll_pend_reg && state_one)
    begin
      if (tx_cnt_reg == TX_BITS) // [RULE1]
      begin
        tx_busy_reg <= 1'b0;
        tx_cnt_reg <= '0;
      end
      else
      begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
        // The first placement only uncovers the start bit already in bit zero.
        if (tx_cnt_reg != '0)
          tx_shift_reg <= {1'b1, tx_shift_reg[10:1]}; // [RULE7]
      end
    end
  end

  // Line idles high and shows the current frame bit after it has been placed.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      txd <= 1'b1;
    else if (!tx_busy_reg || tx_cnt_reg == '0)
      txd <= 1'b1; // [RULE16]
    else
      txd <= tx_shift_reg[0];
  end

  // Set wins over clear; the flag rises as the stop bit is placed, the frame ends a bit later.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tx_done_flag <= 1'b0;
    else if (tx_busy_reg && tx_roll_pend_reg && state_one && tx_cnt_reg == TX_BITS - 4'h1)
      tx_done_flag <= 1'b1; // [RULE9] [RULE17]
    else if (tx_done_clear)
      tx_done_flag <= 1'b0;
  end

  // Receiver.
  assign fall = rxd_prev_reg && !rxd_reg; // [RULE11]
  assign rx_bit = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & vote_reg[2])
                | (vote_reg[1] & vote_reg[2]); // [RULE13]

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rx_div_reg <= '0;
    else if (rx_state_reg == RX_IDLE && fall)
      rx_div_reg <= '0; // [RULE12]
    else if (tick)
      rx_div_reg <= rx_div_reg + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      vote_reg <= '0;
    else if (tick && (rx_div_reg == SAMPLE_A || rx_div_reg == SAMPLE_B
                      || rx_div_reg == SAMPLE_C))
      vote_reg <= {vote_reg[1:0], rxd_reg}; // [RULE13]
  end

  logic rx_resolve;
  assign rx_resolve = tick && (rx_div_reg == SLICE_LAST);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_shift_reg <= '0;
    end
    else
    begin
      unique case (rx_state_reg)
        RX_IDLE:
        begin
          rx_cnt_reg <= '0;
          if (rx_enable && fall) // [RULE10] [RULE11]
            rx_state_reg <= RX_SHIFT;
        end
        RX_SHIFT:
        begin
          if (rx_resolve)
          begin
            if (rx_cnt_reg == '0 && rx_bit)
              rx_state_reg <= RX_IDLE; // [RULE14]
            else
            begin
              rx_cnt_reg <= rx_cnt_reg + 4'h1;
              if (rx_cnt_reg != '0 && rx_cnt_reg != RX_BITS)
                rx_shift_reg <= {rx_bit, rx_shift_reg[8:1]}; // [RULE2]
              if (rx_cnt_reg == RX_BITS)
                rx_state_reg <= RX_LOAD; // [RULE15]
            end
          end
        end
        RX_LOAD:
          rx_state_reg <= RX_IDLE;
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Loading is not gated on the stop bit reading high; other load conditions are left open.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_buffer_rdata <= '0;
      rx_ninth_bit <= 1'b0;
    end
    else if (rx_state_reg == RX_LOAD)
    begin
      serial_buffer_rdata <= rx_shift_reg[7:0]; // [RULE15]
      rx_ninth_bit <= rx_shift_reg[8]; // [RULE4]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rx_done_flag <= 1'b0;
    else if (rx_state_reg == RX_LOAD)
      rx_done_flag <= 1'b1; // [RULE15] [RULE17]
    else if (rx_done_clear)
      rx_done_flag <= 1'b0;
  end

  assign serial_irq = tx_done_flag || rx_done_flag; // [RULE17]

  // Checks.
  logic [7:0] tx_roll_seen_reg;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tx_roll_seen_reg <= '0;
    else if (!tx_busy_reg)
      tx_roll_seen_reg <= '0;
    else if (tx_roll)
      tx_roll_seen_reg <= tx_roll_seen_reg + 8'h01;
  end

  tx_idle_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE16]
    !tx_busy_reg |=> txd)
    else $error("Transmit line not high while idle.");
  tx_start_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
    (tx_busy_reg && tx_cnt_reg == 4'h1) |=> !txd)
    else $error("Start bit not low.");
  tx_bit_state_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
    $changed(tx_cnt_reg) && tx_busy_reg |-> $past(state_reg) == STATE_ONE)
    else $error("Transmit bit moved outside state one.");
  tx_done_eleven_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE9]
    $rose(tx_done_flag) |-> $past(tx_roll_seen_reg) == 8'h0B)
    else $error("Transmit done not at eleventh rollover.");
  tx_write_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE6]
    $rose(tx_busy_reg) |-> $past(txq.valid))
    else $error("Transmission started without a buffered write.");
  rx_enable_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE10]
    (rx_state_reg == RX_IDLE && !rx_enable) |=> rx_state_reg == RX_IDLE)
    else $error("Receiver started while disabled.");
  rx_div_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE12]
    (rx_state_reg == RX_IDLE && rx_enable && fall) |=> rx_div_reg == 4'h0)
    else $error("Receive counter not reset on edge.");
  rx_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE14]
    (rx_resolve && rx_state_reg == RX_SHIFT && rx_cnt_reg == 4'h0 && rx_bit)
    |=> rx_state_reg == RX_IDLE && !rx_done_flag[*1])
    else $error("Bad start bit not aborted.");
  rx_load_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE15]
    rx_state_reg == RX_LOAD |=> rx_done_flag && rx_ninth_bit == $past(rx_shift_reg[8]))
    else $error("Receive load did not set flag or ninth bit.");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE17]
    tx_done_flag && !tx_done_clear |=> tx_done_flag && serial_irq)
    else $error("Transmit flag or interrupt dropped without clear.");

  tx_frame_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(tx_done_flag));
  rx_frame_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(rx_done_flag));
  rx_abort_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_state_reg == RX_SHIFT ##1 rx_state_reg == RX_IDLE && !rx_done_flag);
  fifo_full_c: cover property (@(posedge clk_sys) disable iff (!rst_n) !serial_buffer_ready);
endmodule // serial_port_nine_bit

// ==== tb/remote_serial_model.sv ====
// Far-side serial partner: sends frames on rxd and decodes the frames it sees on txd.
// Assumes the bench sets bit_clks to the bit time in clk_sys cycles and keeps it between frames.
`timescale 1ns/1ps
module remote_serial_model (
  // Clock and bit time
  input wire logic clk_sys,
  input wire logic [6:0] bit_clks,
  // Serial lines
  input wire logic txd,
  output logic rxd,
  // Decoded frames
  output logic got_valid,
  output logic [9:0] got_word
);
  int i;
  initial
  begin
    rxd = 1'b1;
    got_valid = 1'b0;
    got_word = 10'h000;
  end
  // A start shorter than one bit time is a glitch: the line goes back high and nothing follows.
  task automatic send(input logic [8:0] w, input int start_clks);
    logic [9:0] fr;
    int k;
    fr = {1'b1, w};
    @(posedge clk_sys);
    #1 rxd = 1'b0;
    repeat (start_clks) @(posedge clk_sys);
    for (k = 0; k < 10 && start_clks >= bit_clks; k++)
    begin
      #1 rxd = fr[k];
      repeat (bit_clks) @(posedge clk_sys);
    end
    #1 rxd = 1'b1;
  endtask
  // Mid-bit sampling keeps the decoder tolerant of where the start edge lands in a clock.
  always
  begin : decode
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk_sys);
    for (i = 0; i < 10; i++)
    begin
      repeat (bit_clks) @(posedge clk_sys);
      got_word[i] = txd;
    end
    got_valid = 1'b1;
    @(posedge clk_sys);
    got_valid = 1'b0;
  end
endmodule // remote_serial_model

// ==== tb/tb.sv ====
// Self-checking bench for the nine-bit serial port with its far-side partner model.
// Assumes the design package and the partner model are compiled first.
`timescale 1ns/1ps
module tb;
  import uart9_pkg::*;
  logic clk_sys, arst_n, serial_buffer_write, serial_buffer_ready, tx_ninth_bit;
  logic baud_double_select, rx_enable, rx_ninth_bit, tx_done_flag, rx_done_flag;
  logic tx_done_clear, rx_done_clear, serial_irq, txd, rxd, got_valid;
  logic [7:0] serial_buffer_wdata, serial_buffer_rdata;
  logic [6:0] bit_clks;
  logic [9:0] got_word;
  logic [31:0] seed;
  logic [8:0] w;
  logic [9:0] tx_q[$];
  logic [8:0] rx_q[$];
  int errors, check_count, m, n;

  serial_port_nine_bit serial_port_nine_bit_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .serial_buffer_wdata(serial_buffer_wdata), .serial_buffer_write(serial_buffer_write),
    .serial_buffer_ready(serial_buffer_ready), .tx_ninth_bit(tx_ninth_bit),
    .baud_double_select(baud_double_select), .rx_enable(rx_enable),
    .serial_buffer_rdata(serial_buffer_rdata), .rx_ninth_bit(rx_ninth_bit),
    .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag), .tx_done_clear(tx_done_clear),
    .rx_done_clear(rx_done_clear), .serial_irq(serial_irq), .txd(txd), .rxd(rxd));
  remote_serial_model remote_serial_model_i (.clk_sys(clk_sys), .bit_clks(bit_clks),
    .txd(txd), .rxd(rxd), .got_valid(got_valid), .got_word(got_word));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tally(input logic ok, input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_frame(input logic [9:0] got, input logic [9:0] exp);
    tally(got === exp, got, exp);
  endtask
  task automatic check_rx(input logic [8:0] got, input logic [8:0] exp);
    tally(got === exp, {1'b0, got}, {1'b0, exp});
  endtask
  task automatic check_flag(input logic got, input logic exp);
    tally(got === exp, {9'h000, got}, {9'h000, exp});
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic expire();
    errors++;
    $display("[ERR] t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  endtask
  task automatic wait_high(ref logic sig, input int limit);
    int k;
    for (k = 0; k < limit && sig !== 1'b1; k++)
      @(posedge clk_sys);
    if (sig !== 1'b1)
      expire();
  endtask

  // A refused write leaves no expectation, so a dropped word must never reach the line.
  task automatic sb_write(input logic [8:0] v);
    @(posedge clk_sys);
    #1;
    serial_buffer_wdata = v[7:0];
    tx_ninth_bit = v[8];
    serial_buffer_write = 1'b1;
    if (serial_buffer_ready === 1'b1)
      tx_q.push_back({1'b1, v});
    @(posedge clk_sys);
    #1 serial_buffer_write = 1'b0;
  endtask
  task automatic pulse_clear(input logic tx_side);
    @(posedge clk_sys);
    #1;
    tx_done_clear = tx_side;
    rx_done_clear = ~tx_side;
    @(posedge clk_sys);
    #1;
    tx_done_clear = 1'b0;
    rx_done_clear = 1'b0;
  endtask
  task automatic rx_frame(input int start_clks, input logic expect_load);
    seed = xorshift(seed);
    if (expect_load)
      rx_q.push_back(seed[8:0]);
    remote_serial_model_i.send(seed[8:0], start_clks);
    repeat (3 * bit_clks) @(posedge clk_sys);
  endtask

  always @(posedge got_valid)
  begin
    if (tx_q.size() == 0)
      tally(1'b0, got_word, 10'h3FF);
    else
      check_frame(got_word, tx_q.pop_front());
  end
  always @(posedge rx_done_flag)
  begin
    #1;
    if (rx_q.size() == 0)
      tally(1'b0, {1'b0, rx_ninth_bit, serial_buffer_rdata}, 10'h3FF);
    else
      check_rx({rx_ninth_bit, serial_buffer_rdata}, rx_q.pop_front());
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    expire();
  end

  initial
  begin
    errors = 0;
    check_count = 0;
    seed = 32'h0000_6053;
    arst_n = 1'b0;
    serial_buffer_wdata = 8'h00;
    serial_buffer_write = 1'b0;
    tx_ninth_bit = 1'b0;
    baud_double_select = 1'b0;
    rx_enable = 1'b0;
    tx_done_clear = 1'b0;
    rx_done_clear = 1'b0;
    bit_clks = 7'h40;
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    check_flag(txd, 1'b1);
    check_flag(serial_irq, 1'b0);
    for (m = 0; m < 2; m++)
    begin
      baud_double_select = m[0];
      bit_clks = m[0] ? 7'h20 : 7'h40;
      for (n = 0; n < 6; n++)
      begin
        seed = xorshift(seed);
        sb_write(seed[8:0]);
      end
      check_flag(serial_buffer_ready, 1'b0);
      // Reception runs while the transmit queue drains, so both directions overlap.
      rx_enable = 1'b1;
      rx_frame(int'(bit_clks), 1'b1);
      wait_high(rx_done_flag, 2000);
      repeat (100) @(posedge clk_sys);
      check_flag(rx_done_flag, 1'b1);
      pulse_clear(1'b0);
      check_flag(rx_done_flag, 1'b0);
      rx_frame(8, 1'b0);
      rx_frame(int'(bit_clks), 1'b1);
      wait_high(rx_done_flag, 2000);
      pulse_clear(1'b0);
      rx_enable = 1'b0;
      rx_frame(int'(bit_clks), 1'b0);
      check_flag(rx_done_flag, 1'b0);
      for (n = 0; n < 30000 && tx_q.size() != 0; n++)
        @(posedge clk_sys);
      if (tx_q.size() != 0)
        expire();
      wait_high(tx_done_flag, 2000);
      repeat (100) @(posedge clk_sys);
      check_flag(serial_irq, 1'b1);
      pulse_clear(1'b1);
      check_flag(tx_done_flag, 1'b0);
      check_flag(serial_irq, 1'b0);
      $display("baud mode %0d done", m);
    end
    conclude();
  end
endmodule // tb
